// ---- coax_eq_checker_asserts.sv ----
// Purpose: Port-level checks of the equalizer register bank.
// Assumes: One clock domain, REF_CLK, reset ARST_N.
// Notes: Pin paths get 10 cycles; sync latency is about 5.
`timescale 1ns/1ps
module coax_eq_checker (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic SS_N,
  input wire logic MISO,
  input wire logic MISO_OE_N,
  input wire logic DRIVER_ENABLE_IN,
  input wire logic EDGE_RATE_SELECT_IN,
  input wire logic EQ_POWERED,
  input wire logic EQ_SERIAL_OUT_ZERO,
  input wire logic [2:0] OUT_SWING,
  input wire logic [2:0] OUT_COMMON_MODE,
  input wire logic OUT_CM_SUPPLY_REF,
  input wire logic LAUNCH_COARSE,
  input wire logic [3:0] LAUNCH_FINE,
  input wire logic DRIVER_POWERED,
  input wire logic SLOW_EDGES
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  AST_ZERO_NEEDS_POWER: assert property (
    EQ_SERIAL_OUT_ZERO |-> EQ_POWERED) else $error("Muted while asleep");
  AST_SWING_RESET: assert property (
    $rose(ARST_N) |-> OUT_SWING == 3'h3) else $error("Swing reset");
  AST_CM_RESET: assert property (
    $rose(ARST_N) |-> OUT_COMMON_MODE == 3'h1 && !OUT_CM_SUPPLY_REF)
    else $error("Common mode reset");
  AST_LAUNCH_RESET: assert property (
    $rose(ARST_N) |-> !LAUNCH_COARSE && LAUNCH_FINE == 4'h0)
    else $error("Launch reset");
  AST_CM_SUPPLY: assert property (
    $stable(OUT_COMMON_MODE)[*3] |->
    OUT_CM_SUPPLY_REF == (OUT_COMMON_MODE == 3'h5))
    else $error("Supply reference");
  AST_DRIVER_PIN: assert property (
    $stable(DRIVER_ENABLE_IN)[*8] |->
    ##2 DRIVER_POWERED == $past(DRIVER_ENABLE_IN, 2))
    else $error("Driver power");
  AST_EDGE_PIN: assert property (
    $stable(EDGE_RATE_SELECT_IN)[*8] |->
    ##2 SLOW_EDGES == $past(EDGE_RATE_SELECT_IN, 2))
    else $error("Edge rate");
  AST_MISO_IDLE: assert property (
    SS_N[*8] |-> MISO_OE_N && !MISO) else $error("Serial out idle");
  AST_CFG_HOLD: assert property (
    SS_N[*8] |=> $stable(OUT_SWING) && $stable(LAUNCH_FINE)
    && $stable(LAUNCH_COARSE)) else $error("Config moved idle");
endmodule : coax_eq_checker

bind coax_eq_config_registers coax_eq_checker i_chk (
  .REF_CLK(REF_CLK), .ARST_N(ARST_N), .SS_N(SS_N), .MISO(MISO),
  .MISO_OE_N(MISO_OE_N), .DRIVER_ENABLE_IN(DRIVER_ENABLE_IN),
  .EDGE_RATE_SELECT_IN(EDGE_RATE_SELECT_IN), .EQ_POWERED(EQ_POWERED),
  .EQ_SERIAL_OUT_ZERO(EQ_SERIAL_OUT_ZERO), .OUT_SWING(OUT_SWING),
  .OUT_COMMON_MODE(OUT_COMMON_MODE),
  .OUT_CM_SUPPLY_REF(OUT_CM_SUPPLY_REF), .LAUNCH_COARSE(LAUNCH_COARSE),
  .LAUNCH_FINE(LAUNCH_FINE), .DRIVER_POWERED(DRIVER_POWERED),
  .SLOW_EDGES(SLOW_EDGES));

// ---- coax_eq_config_registers.sv ----
// Purpose: Serial-port register bank of a coax equalizer / cable driver.
// Assumes: Serial pins are slow against REF_CLK (each level >= 4 clocks).
// Notes:   Serial clock, select and data are oversampled on REF_CLK.
// Overview of operation
// - Sleep code 01 default: sleep without input
// - Sleep code 00 keeps equalizer always powered
// - Sleep code 10 forces equalizer powered down
// - Sleep takes priority over mute
// - Swing field 01h[7:5], reset 011
// - Common-mode field 01h[4:2], reset 001
// - Common-mode code 101 references positive supply
// - 02h bit 7 selects 6 dB coarse compensation
// - Fine gain 02h[6:3], reset 0000, nominal 0110
// - 03h[7:3] reports cable length 0 to 25
// - Driver enable pin low powers driver off
// - Edge-rate pin high slow, low fast
// - Read data shifts out from eighth falling edge
// - Mute bit forces equalizer outputs to zero
`timescale 1ns/1ps
`include "coax_eq_defs.svh"
module coax_eq_config_registers
  import coax_eq_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic SCK,
  input wire logic SS_N,
  input wire logic MOSI,
  output logic MISO,
  output logic MISO_OE_N,
  input wire logic CARRIER_IN,
  input wire logic DRIVER_ENABLE_IN,
  input wire logic EDGE_RATE_SELECT_IN,
  input wire logic [4:0] CABLE_LENGTH_IN,
  output logic EQ_POWERED,
  output logic EQ_SERIAL_OUT_ZERO,
  output logic EQ_EXT_REACH,
  output logic [2:0] OUT_SWING,
  output logic [2:0] OUT_COMMON_MODE,
  output logic OUT_CM_SUPPLY_REF,
  output logic LAUNCH_COARSE,
  output logic [3:0] LAUNCH_FINE,
  output logic DRIVER_POWERED,
  output logic SLOW_EDGES
);
  typedef struct packed {
    frame_state_t fsm;
    logic [3:0] cnt;
    logic [14:0] sh;
    logic [7:0] out_sh;
    logic miso;
    logic miso_oe_n;
    eq_cfg_t cfg;
    logic carrier;
    logic [4:0] cable_length_indicator;
  } bank_state_t;

  localparam eq_cfg_t CFG_RST = '{
    `MUTE_RST, `SLEEP_RST, `REACH_RST, `SWING_RST,
    `CM_RST, `COARSE_RST, `FINE_RST
  };

  localparam bank_state_t BANK_RST = '{
    FRAME_IDLE, 4'h0, 15'h0000, 8'h00, 1'b0, 1'b1, CFG_RST, 1'b0, 5'h00
  };

  // The frame decoder is written for an eight-bit header and a
  // sixteen-bit frame; other defines would misplace every field
  if (`HEADER_LAST_BIT != 4'h7) begin : g_header_chk
    $error("Serial header must be eight bits long");
  end
  if (`FRAME_LAST_BIT != 4'hF) begin : g_frame_chk
    $error("Serial frame must be sixteen bits long");
  end
  if (`CLI_MSB - `CLI_LSB != 4) begin : g_cli_chk
    $error("Cable length field must be five bits wide");
  end
  if (`SWING_MSB - `SWING_LSB != 2) begin : g_swing_chk
    $error("Output swing field must be three bits wide");
  end

  logic [1:0] rst_pipe;
  logic rst_n;

  // Release of the external reset is retimed to REF_CLK
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  serial_pins_t ser_d;
  serial_pins_t ser_q;
  serial_pins_t ser_rise;
  serial_pins_t ser_fall;
  status_pins_t sta_d;
  status_pins_t sta_q;

  assign ser_d = '{SCK, SS_N, MOSI};
  assign sta_d = '{CARRIER_IN, DRIVER_ENABLE_IN, EDGE_RATE_SELECT_IN,
                   CABLE_LENGTH_IN};

  pin_sync3 #(
    .W(3),
    .RST_VAL(3'h2)
  ) u_ser_sync (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .d(ser_d),
    .q(ser_q),
    .rise(ser_rise),
    .fall(ser_fall)
  );

  // Driver enable idles high, edge select low, as the pin pulls do
  pin_sync3 #(
    .W(8),
    .RST_VAL(8'h40)
  ) u_sta_sync (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .d(sta_d),
    .q(sta_q),
    .rise(),
    .fall()
  );

  bank_state_t st;
  bank_state_t next_st;
  logic [6:0] raddr;
  logic [6:0] waddr;
  logic [7:0] wdata;

  // The last header or data bit comes straight from the synced pin and
  // the earlier ones from the shifter, so no extra clock is spent
  assign raddr = {st.sh[5:0], ser_q.mosi};
  assign waddr = st.sh[13:7];
  assign wdata = {st.sh[6:0], ser_q.mosi};

  function automatic logic [7:0] read_reg(input logic [6:0] addr,
                                          input bank_state_t s);
    logic [7:0] v;
    v = 8'h00;
    unique case (addr)
      `ADDR_GENERAL: begin
        v[`CD_BIT] = s.carrier;
        v[`MUTE_BIT] = s.cfg.mute;
        v[`SLEEP_MSB:`SLEEP_LSB] = s.cfg.sleep;
        v[`REACH_BIT] = s.cfg.ext_reach;
      end
      `ADDR_OUT_LEVEL: begin
        v[`SWING_MSB:`SWING_LSB] = s.cfg.swing;
        v[`CM_MSB:`CM_LSB] = s.cfg.cm;
      end
      `ADDR_LAUNCH: begin
        v[`COARSE_BIT] = s.cfg.coarse;
        v[`FINE_MSB:`FINE_LSB] = s.cfg.fine;
      end
      `ADDR_CABLE_LEN: begin
        v[`CLI_MSB:`CLI_LSB] = s.cable_length_indicator;
      end
      default: begin
        v = 8'h00;
      end
    endcase
    return v;
  endfunction : read_reg

  always_comb begin
    next_st = st;
    next_st.carrier = sta_q.carrier;
    // Measurement beyond the documented span is clamped
    if (sta_q.cable_len > `CLI_MAX) begin
      next_st.cable_length_indicator = `CLI_MAX;
    end else begin
      next_st.cable_length_indicator = sta_q.cable_len;
    end

    if (ser_q.ss_n) begin
      // Select high ends any frame and releases the data line
      next_st.fsm = FRAME_IDLE;
      next_st.cnt = 4'h0;
      next_st.miso = 1'b0;
      next_st.miso_oe_n = 1'b1;
    end else begin
      unique case (st.fsm)
        FRAME_IDLE: begin
          next_st.fsm = FRAME_HEADER;
          next_st.cnt = 4'h0;
          if (ser_rise.sck) begin
            next_st.sh = {st.sh[13:0], ser_q.mosi};
            next_st.cnt = 4'h1;
          end
        end
        FRAME_HEADER: begin
          if (ser_rise.sck) begin
            next_st.sh = {st.sh[13:0], ser_q.mosi};
            next_st.cnt = st.cnt + 4'h1;
            if (st.cnt == `HEADER_LAST_BIT) begin
              if (st.sh[6]) begin
                next_st.out_sh = read_reg(raddr, st);
                next_st.fsm = FRAME_READ;
              end else begin
                next_st.fsm = FRAME_WRITE;
              end
            end
          end
        end
        FRAME_READ: begin
          if (ser_fall.sck) begin
            next_st.miso = st.out_sh[7];
            next_st.miso_oe_n = 1'b0;
            next_st.out_sh = {st.out_sh[6:0], 1'b0};
          end
        end
        FRAME_WRITE: begin
          if (ser_rise.sck) begin
            next_st.sh = {st.sh[13:0], ser_q.mosi};
            next_st.cnt = st.cnt + 4'h1;
            if (st.cnt == `FRAME_LAST_BIT) begin
              next_st.fsm = FRAME_DONE;
              unique case (waddr)
                `ADDR_GENERAL: begin
                  next_st.cfg.mute = wdata[`MUTE_BIT];
                  next_st.cfg.sleep = wdata[`SLEEP_MSB:`SLEEP_LSB];
                  next_st.cfg.ext_reach = wdata[`REACH_BIT];
                end
                `ADDR_OUT_LEVEL: begin
                  next_st.cfg.swing = wdata[`SWING_MSB:`SWING_LSB];
                  next_st.cfg.cm = wdata[`CM_MSB:`CM_LSB];
                end
                `ADDR_LAUNCH: begin
                  next_st.cfg.coarse = wdata[`COARSE_BIT];
                  next_st.cfg.fine = wdata[`FINE_MSB:`FINE_LSB];
                end
                default: begin
                  // Cable length and unmapped addresses keep state
                  next_st.cfg = st.cfg;
                end
              endcase
            end
          end
        end
        FRAME_DONE: begin
          // Extra clocks past sixteen bits are ignored until select rises
          next_st.fsm = FRAME_DONE;
        end
        default: begin
          next_st.fsm = FRAME_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      st <= BANK_RST;
    end else begin
      st <= next_st;
    end
  end

  logic eq_powered;
  logic out_zero;
  logic cm_supply;
  logic driver_powered;
  logic slow_edges;

  eq_power_ctrl u_power (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .cfg(st.cfg),
    .carrier(st.carrier),
    .drv_enable(sta_q.drv_enable),
    .edge_slow(sta_q.edge_slow),
    .eq_powered(eq_powered),
    .out_zero(out_zero),
    .cm_supply(cm_supply),
    .driver_powered(driver_powered),
    .slow_edges(slow_edges)
  );

  assign MISO = st.miso;
  assign MISO_OE_N = st.miso_oe_n;
  assign EQ_POWERED = eq_powered;
  assign EQ_SERIAL_OUT_ZERO = out_zero;
  assign EQ_EXT_REACH = st.cfg.ext_reach;
  assign OUT_SWING = st.cfg.swing;
  assign OUT_COMMON_MODE = st.cfg.cm;
  assign OUT_CM_SUPPLY_REF = cm_supply;
  assign LAUNCH_COARSE = st.cfg.coarse;
  assign LAUNCH_FINE = st.cfg.fine;
  assign DRIVER_POWERED = driver_powered;
  assign SLOW_EDGES = slow_edges;
endmodule : coax_eq_config_registers

// ---- coax_eq_defs.svh ----
// Purpose: Offsets, field positions, reset values and codes of the
//          equalizer configuration registers.
// Assumes: Included by bare name; definitions only.
// Notes:   Addresses are the 7-bit serial frame addresses.
`ifndef COAX_EQ_DEFS_SVH
`define COAX_EQ_DEFS_SVH

`define ADDR_GENERAL 7'h00
`define ADDR_OUT_LEVEL 7'h01
`define ADDR_LAUNCH 7'h02
`define ADDR_CABLE_LEN 7'h03

`define CD_BIT 7
`define MUTE_BIT 6
`define SLEEP_MSB 4
`define SLEEP_LSB 3
`define REACH_BIT 2
`define SWING_MSB 7
`define SWING_LSB 5
`define CM_MSB 4
`define CM_LSB 2
`define COARSE_BIT 7
`define FINE_MSB 6
`define FINE_LSB 3
`define CLI_MSB 7
`define CLI_LSB 3

`define MUTE_RST 1'h0
`define SLEEP_RST 2'h1
`define REACH_RST 1'h0
`define SWING_RST 3'h3
`define CM_RST 3'h1
`define COARSE_RST 1'h0
`define FINE_RST 4'h0

`define SLEEP_NEVER 2'h0
`define SLEEP_AUTO 2'h1
`define SLEEP_FORCE 2'h2
`define CM_SUPPLY_CODE 3'h5
`define CLI_MAX 5'h19

`define FRAME_LAST_BIT 4'hF
`define HEADER_LAST_BIT 4'h7

`endif

// ---- coax_eq_pkg.sv ----
// Purpose: Types shared by the equalizer configuration logic.
// Assumes: Constants live in coax_eq_defs.svh.
// Notes:   Frame states are one-hot.
package coax_eq_pkg;

  typedef enum logic [4:0] {
    FRAME_IDLE = 5'b00001,
    FRAME_HEADER = 5'b00010,
    FRAME_READ = 5'b00100,
    FRAME_WRITE = 5'b01000,
    FRAME_DONE = 5'b10000
  } frame_state_t;

  typedef struct packed {
    logic mute;
    logic [1:0] sleep;
    logic ext_reach;
    logic [2:0] swing;
    logic [2:0] cm;
    logic coarse;
    logic [3:0] fine;
  } eq_cfg_t;

  typedef struct packed {
    logic sck;
    logic ss_n;
    logic mosi;
  } serial_pins_t;

  typedef struct packed {
    logic carrier;
    logic drv_enable;
    logic edge_slow;
    logic [4:0] cable_len;
  } status_pins_t;

endpackage : coax_eq_pkg

// ---- eq_power_ctrl.sv ----
// Purpose: Equalizer power, output mute and cable driver pin decisions.
// Assumes: Inputs already synchronised to clk.
// Notes:   All outputs are registered.
`timescale 1ns/1ps
`include "coax_eq_defs.svh"
module eq_power_ctrl
  import coax_eq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input eq_cfg_t cfg,
  input wire logic carrier,
  input wire logic drv_enable,
  input wire logic edge_slow,
  output logic eq_powered,
  output logic out_zero,
  output logic cm_supply,
  output logic driver_powered,
  output logic slow_edges
);
  typedef struct packed {
    logic eq_powered;
    logic out_zero;
    logic cm_supply;
    logic driver_powered;
    logic slow_edges;
  } pwr_state_t;

  // Driver enabled until the pin is seen low, fast edges by default
  localparam pwr_state_t PWR_RST = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

  pwr_state_t st;
  pwr_state_t next_st;

  always_comb begin
    next_st = st;
    unique case (cfg.sleep)
      `SLEEP_AUTO: next_st.eq_powered = carrier;
      `SLEEP_NEVER: next_st.eq_powered = 1'b1;
      `SLEEP_FORCE: next_st.eq_powered = 1'b0;
      default: next_st.eq_powered = 1'b1;
    endcase
    // Mute only acts on a powered equalizer
    next_st.out_zero = cfg.mute & next_st.eq_powered;
    next_st.cm_supply = (cfg.cm == `CM_SUPPLY_CODE);
    next_st.driver_powered = drv_enable;
    next_st.slow_edges = edge_slow;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= PWR_RST;
    end else begin
      st <= next_st;
    end
  end

  assign eq_powered = st.eq_powered;
  assign out_zero = st.out_zero;
  assign cm_supply = st.cm_supply;
  assign driver_powered = st.driver_powered;
  assign slow_edges = st.slow_edges;
endmodule : eq_power_ctrl

// ---- pin_sync3.sv ----
// Purpose: Three-stage synchroniser with agreement filter and edge pulses.
// Assumes: Inputs are asynchronous to clk.
// Notes:   A change counts only once stages two and three agree.
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  if (W < 1) begin : g_chk
    $error("pin_sync3 needs at least one bit");
  end

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
  } sync_state_t;

  localparam sync_state_t SYNC_RST =
    '{RST_VAL, RST_VAL, RST_VAL, RST_VAL, '0, '0};

  sync_state_t st;
  sync_state_t next_st;
  logic [W-1:0] agree;

  always_comb begin
    next_st = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    agree = ~(st.s2 ^ st.s3);
    next_st.q = (agree & st.s3) | (~agree & st.q);
    next_st.rise = agree & st.s3 & ~st.q;
    next_st.fall = agree & ~st.s3 & st.q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= SYNC_RST;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.q;
  assign rise = st.rise;
  assign fall = st.fall;
endmodule : pin_sync3

// ---- serial_host.sv ----
// Purpose: Serial host framing register reads and writes.
// Assumes: Every serial level is held at least 6 REF_CLK cycles.
// Notes: Released data line toggles so no stale level is read.
`timescale 1ns/1ps
module serial_host (
  input wire logic clk,
  input wire logic miso,
  output logic sck,
  output logic ss_n,
  output logic mosi
);
  initial begin
    sck = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic xfer(input logic rd, input logic [6:0] a,
      input logic [7:0] wd, output logic [7:0] rdat);
    logic [15:0] sh;
    sh = {rd, a, wd};
    rdat = 8'h00;
    @(negedge clk) ss_n <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      repeat (6) @(negedge clk);
      if (rd && i > 7) begin
        rdat = {rdat[6:0], miso};
        mosi <= ~mosi;
      end else begin
        mosi <= sh[15 - i];
      end
      repeat (6) @(negedge clk);
      sck <= 1'b1;
      repeat (6) @(negedge clk);
      sck <= 1'b0;
    end
    repeat (12) @(negedge clk);
    ss_n <= 1'b1;
    repeat (6) @(negedge clk);
  endtask : xfer
endmodule : serial_host

// ---- testbench.sv ----
// Purpose: Self-checking bench of the equalizer register bank.
// Assumes: Serial host model drives the frames.
// Notes: Reserved bits are masked in the model, not stored apart.
`timescale 1ns/1ps
module testbench;
  logic REF_CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic carrier = 1'b0, drv_en = 1'b1, edge_sel = 1'b0;
  logic [4:0] cable_len = 5'h00;
  logic sck, ss_n, mosi, miso;
  logic eq_pwr, out_zero, cm_ref, coarse, drv_pwr, slow;
  logic miso_oe_n, reach, host_miso;
  logic [2:0] swing, cm;
  logic [3:0] fine;
  int failures = 0, comparisons = 0, cycles = 0, oe_low = 0;
  int model [3] = '{8'h08, 8'h64, 8'h00};
  logic [31:0] seed = 32'h6BEE;
  always #20 REF_CLK = ~REF_CLK;
  serial_host i_serial_host (.clk(REF_CLK), .miso(host_miso), .sck(sck),
    .ss_n(ss_n), .mosi(mosi));
  coax_eq_config_registers i_coax_eq_config_registers (
    .REF_CLK(REF_CLK), .ARST_N(ARST_N), .SCK(sck), .SS_N(ss_n),
    .MOSI(mosi), .MISO(miso), .MISO_OE_N(miso_oe_n), .CARRIER_IN(carrier),
    .DRIVER_ENABLE_IN(drv_en), .EDGE_RATE_SELECT_IN(edge_sel),
    .CABLE_LENGTH_IN(cable_len), .EQ_POWERED(eq_pwr),
    .EQ_SERIAL_OUT_ZERO(out_zero), .EQ_EXT_REACH(reach),
    .OUT_SWING(swing),
    .OUT_COMMON_MODE(cm), .OUT_CM_SUPPLY_REF(cm_ref),
    .LAUNCH_COARSE(coarse), .LAUNCH_FINE(fine),
    .DRIVER_POWERED(drv_pwr), .SLOW_EDGES(slow));
  // A released data line shows the inverse of the design's idle level
  assign host_miso = miso_oe_n ? ~miso : miso;
  always @(negedge REF_CLK) begin
    if (!miso_oe_n) oe_low++;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  task automatic compare(input string n, input logic [7:0] e,
      input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : compare
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    int n;
    n = oe_low;
    i_serial_host.xfer(1'b0, a, d, r);
    compare("oe_write", 8'h00, 8'(oe_low != n));
    if (a < 7'h03) model[a] = d;
    repeat (10) @(negedge REF_CLK);
  endtask : wr
  task automatic rd(input logic [6:0] a);
    logic [7:0] r, e;
    int n;
    case (a)
      7'h00: e = {carrier, 7'(model[0]) & 7'h5C};
      7'h01: e = 8'(model[1]) & 8'hFC;
      7'h02: e = 8'(model[2]) & 8'hF8;
      7'h03: e = {(cable_len > 5'h19) ? 5'h19 : cable_len, 3'h0};
      default: e = 8'h00;
    endcase
    n = oe_low;
    i_serial_host.xfer(1'b1, a, 8'h00, r);
    compare("read", e, r);
    compare("oe_read", 8'h01, 8'(oe_low != n));
    compare("oe_idle", 8'h01, 8'(miso_oe_n));
  endtask : rd
  task automatic check_outs();
    logic [7:0] m1, m2;
    m1 = 8'(model[1]);
    m2 = 8'(model[2]);
    compare("swing", 8'(m1[7:5]), 8'(swing));
    compare("cm", 8'(m1[4:2]), 8'(cm));
    compare("cm_ref", 8'(m1[4:2] == 3'h5), 8'(cm_ref));
    compare("coarse", 8'(m2[7]), 8'(coarse));
    compare("fine", 8'(m2[6:3]), 8'(fine));
    compare("drv", 8'(drv_en), 8'(drv_pwr));
    compare("slow", 8'(edge_sel), 8'(slow));
  endtask : check_outs
  task automatic check_power();
    int s;
    logic p;
    s = (model[0] >> 3) & 3;
    p = (s != 2) && (s != 1 || carrier);
    compare("powered", 8'(p), 8'(eq_pwr));
    compare("zero", 8'(p & model[0][6]), 8'(out_zero));
    compare("reach", 8'(model[0][2]), 8'(reach));
  endtask : check_power
  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    repeat (8) @(negedge REF_CLK);
    ARST_N = 1'b1;
    repeat (10) @(negedge REF_CLK);
    check_outs();
    check_power();
    for (int a = 0; a < 4; a++) rd(7'(a));
    rd(7'h10);
    $display("Reset values done");
    // Mute, all four sleep codes and the reach bit in turn
    for (int i = 0; i < 16; i++) begin
      carrier = i[0];
      wr(7'h00, {1'b0, i[1], 1'b0, i[3:2], i[0], 2'h0});
      check_power();
      rd(7'h00);
    end
    $display("Sleep and mute done");
    wr(7'h02, 8'h30);
    check_outs();
    wr(7'h01, 8'h74);
    cable_len = 5'h1F;
    wr(7'h02, 8'h80);
    check_outs();
    rd(7'h03);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      cable_len = seed[20:16];
      edge_sel = seed[21];
      drv_en = seed[22];
      wr(7'h01, seed[7:0]);
      wr(7'h02, seed[15:8]);
      wr(7'h03, seed[31:24]);
      check_outs();
      rd(7'h01);
      rd(7'h02);
      rd(7'h03);
    end
    drv_en = 1'b0;
    repeat (10) @(negedge REF_CLK);
    check_outs();
    $display("Register and pin tests done");
    complete_run();
  end
endmodule : testbench
